/* File: rtl/spi_cfg_pkg.sv */
// constants for the serial configuration port
// Functional notes
// R1 - first 16 rising edges form instruction
// R2 - select high then low restarts instruction
// R3 - one data byte per eight clocks
// R4 - bytes apply at last bit; tuning on load
// R5 - instruction bit 15 set means read
// R6 - low 15 bits start; device steps address
// R7 - step bits set increment, else decrement
// R8 - sample on rising, launch on falling
// R9 - host keeps serial clock at most 80 MHz
// R10 - data pin released while select high
// R11 - host keeps select low whole transfer
// R12 - bit order bits; zero means MSB first
// R13 - low-first sends address, flag, data reversed
// R14 - output-enable bits pick 4-wire or 3-wire
// R15 - config writes use first nibble only
// R16 - 3-wire drives pin only in read data
package spi_cfg_pkg;
   localparam int INSTR_BITS = 16;
   localparam int RW_BIT = 15;
   localparam int ADDR_W = 15;
   localparam int BYTE_BITS = 8;
   localparam int SCLK_MAX_MHZ = 80;
   localparam int CORE_CLK_MHZ = 25;
   localparam logic [14:0] CFG_ADDR = 15'h0000;
   localparam logic [14:0] LOAD_REQ_ADDR = 15'h0008;
   localparam logic [14:0] MAIN_FTW_BASE = 15'h0010;
   localparam logic [14:0] CHAN_FTW_BASE = 15'h0018;
   localparam int FTW_BYTES = 6;
   localparam int FTW_W = 48;
   localparam int N_NCO = 2;
   localparam int LOAD_MAIN_BIT = 0;
   localparam int LOAD_CHAN_BIT = 1;
   localparam int MEM_DEPTH = 64;
   // serial_interface_config field positions
   localparam int SOFT_RST_HI = 7;
   localparam int LSB_FIRST_HI = 6;
   localparam int STEP_UP_HI = 5;
   localparam int SDO_ACT_HI = 4;
   localparam int SDO_ACT_LO = 3;
   localparam int STEP_UP_LO = 2;
   localparam int LSB_FIRST_LO = 1;
   localparam int SOFT_RST_LO = 0;
   localparam logic LSB_FIRST_RST = 1'b0;
   localparam logic STEP_UP_RST = 1'b0;
   localparam logic SDO_ACT_RST = 1'b0;
endpackage

/* File: rtl/cfg_mem_if.sv */
// byte store port between serial engine and register memory
interface cfg_mem_if #(parameter int AW = 6);
   logic we;
   logic [AW-1:0] waddr;
   logic [7:0] wdata;
   logic re;
   logic [AW-1:0] raddr;
   logic [7:0] rdata;
   modport engine (output we, waddr, wdata, re, raddr, input rdata);
   modport store (input we, waddr, wdata, re, raddr, output rdata);
endinterface

/* File: rtl/cfg_byte_mem.sv */
// general configuration byte memory with registered read data
module cfg_byte_mem #(
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk,
   input wire logic rstn,
   cfg_mem_if.store port
);
   logic [7:0] mem_q [0:DEPTH-1];
   logic [DEPTH-1:0] vld_q;
   logic [7:0] rdata_q;

   always_ff @(posedge clk) begin
      if (port.we) begin
         mem_q[port.waddr] <= port.wdata;
      end
   end

   // unwritten bytes read as zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         vld_q <= '0;
         rdata_q <= 8'h00;
      end else begin
         if (port.we) begin
            vld_q[port.waddr] <= 1'b1;
         end
         if (port.re) begin
            rdata_q <= vld_q[port.raddr] ? mem_q[port.raddr] : 8'h00;
         end
      end
   end

   assign port.rdata = rdata_q;
endmodule

/* File: rtl/serial_config_port.sv */
// serial configuration port: frame engine, registers, tuning load
module serial_config_port #(
   parameter int MEM_DEPTH = spi_cfg_pkg::MEM_DEPTH
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic sdo_out,
   output logic sdo_oe,
   output logic [spi_cfg_pkg::FTW_W-1:0] main_tuning_word,
   output logic [spi_cfg_pkg::FTW_W-1:0] channel_tuning_word,
   output logic main_tuning_update,
   output logic channel_tuning_update
);
   localparam int AW = $clog2(MEM_DEPTH);
   localparam int NN = spi_cfg_pkg::N_NCO;
   localparam int FW = spi_cfg_pkg::FTW_W;

   // -----------------------------------------------------------
   // tuning slot decode
   // -----------------------------------------------------------
   // result: {hit, nco, byte index}
   function automatic logic [4:0] ftw_slot(input logic [14:0] a);
      logic [14:0] m;
      logic [14:0] c;
      m = a - spi_cfg_pkg::MAIN_FTW_BASE;
      c = a - spi_cfg_pkg::CHAN_FTW_BASE;
      ftw_slot = 5'h00;
      if (m < 15'(spi_cfg_pkg::FTW_BYTES)) begin
         ftw_slot = {2'b10, m[2:0]};
      end else if (c < 15'(spi_cfg_pkg::FTW_BYTES)) begin
         ftw_slot = {2'b11, c[2:0]};
      end
   endfunction

   function automatic logic is_special(input logic [14:0] a);
      logic [4:0] s;
      s = ftw_slot(a);
      is_special = (a == spi_cfg_pkg::CFG_ADDR) ||
                   (a == spi_cfg_pkg::LOAD_REQ_ADDR) ||
                   s[4];
   endfunction

   // plain byte store: not config, load request or tuning, inside depth
   function automatic logic in_mem(input logic [14:0] a);
      in_mem = !is_special(a) && (a < 15'(MEM_DEPTH));
   endfunction

   // bit of the first nibble on the wire
   function automatic logic first_bit(input logic [7:0] b,
         input logic lo_first, input int hi, input int lo);
      first_bit = lo_first ? b[lo] : b[hi];
   endfunction

   // -----------------------------------------------------------
   // link domain state
   // -----------------------------------------------------------
   logic frame_rst_n;
   logic [4:0] cnt_q;
   logic data_q;
   logic rw_q;
   logic [2:0] bidx_q;
   logic [14:0] addr_q;
   logic [15:0] rx_q;
   logic lsb_q;
   logic step_q;
   logic sdo_act_q;
   logic [NN-1:0][FW-1:0] stage_q;
   logic [NN-1:0][FW-1:0] hold_q;
   logic [NN-1:0] tog_q;
   logic [7:0] other_q;
   logic use_mem_q;
   logic [7:0] tx_q;
   logic out_q;
   logic drive_q;

   logic [15:0] rx_d;
   logic [7:0] byte_in;
   logic instr_done;
   logic byte_done;
   logic wr_commit;
   logic rd_issue;
   logic [14:0] addr_step;
   logic [14:0] rd_addr;
   logic [4:0] wr_slot;
   logic [4:0] rd_slot;
   logic [7:0] cfg_byte;
   logic [7:0] stage_rd;
   logic [7:0] other_d;
   logic use_mem_d;
   logic cfg_wr;
   logic load_wr;
   logic soft_rst;
   logic first_lsb;
   logic first_step;
   logic first_sdo;
   logic tx_load;
   logic [7:0] tx_d;
   logic [7:0] tx_fetch;
   logic [7:0] tx_shift;
   logic tx_bit;

   cfg_mem_if #(.AW(AW)) mem_port ();

   // select high clears every frame register
   assign frame_rst_n = rstn & ~cs_n; // see R2

   // -----------------------------------------------------------
   // receive path
   // -----------------------------------------------------------
   // both orders leave the word as {flag, address}
   assign rx_d = lsb_q ? {sdio_in, rx_q[15:1]}
                       : {rx_q[14:0], sdio_in}; // see R13
   assign byte_in = lsb_q ? rx_d[15:8] : rx_d[7:0]; // see R13
   assign instr_done = !data_q &&
      (cnt_q == 5'(spi_cfg_pkg::INSTR_BITS - 1)); // see R1
   assign byte_done = data_q && (bidx_q == 3'h7); // see R3
   assign wr_commit = byte_done && !rw_q; // see R4
   assign rd_issue = (instr_done && rx_d[spi_cfg_pkg::RW_BIT]) ||
                     (byte_done && rw_q);
   assign addr_step = step_q ? addr_q + 15'h0001
                             : addr_q - 15'h0001; // see R7
   assign rd_addr = instr_done ? rx_d[14:0] : addr_step; // see R6

   // sampling on the rising edge
   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         rx_q <= 16'h0000;
      end else begin
         rx_q <= rx_d; // see R8
      end
   end

   // -----------------------------------------------------------
   // frame sequencer
   // -----------------------------------------------------------
   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         cnt_q <= 5'h00;
         data_q <= 1'b0;
         rw_q <= 1'b0;
      end else if (instr_done) begin
         data_q <= 1'b1; // see R1
         rw_q <= rx_d[spi_cfg_pkg::RW_BIT]; // see R5
      end else if (!data_q) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bidx_q <= 3'h0;
         addr_q <= 15'h0000;
      end else if (instr_done) begin
         bidx_q <= 3'h0;
         addr_q <= rx_d[14:0]; // see R6
      end else if (data_q) begin
         bidx_q <= bidx_q + 3'h1; // see R3
         if (byte_done) begin
            addr_q <= addr_step; // see R7
         end
      end
   end

   // -----------------------------------------------------------
   // interface configuration register
   // -----------------------------------------------------------
   assign wr_slot = ftw_slot(addr_q);
   assign cfg_wr = wr_commit && (addr_q == spi_cfg_pkg::CFG_ADDR);
   assign load_wr = wr_commit &&
                    (addr_q == spi_cfg_pkg::LOAD_REQ_ADDR);

   // only the first nibble on the wire counts
   assign soft_rst = first_bit(byte_in, lsb_q, spi_cfg_pkg::SOFT_RST_HI,
                               spi_cfg_pkg::SOFT_RST_LO);
   assign first_lsb = first_bit(byte_in, lsb_q, spi_cfg_pkg::LSB_FIRST_HI,
                                spi_cfg_pkg::LSB_FIRST_LO);
   assign first_step = first_bit(byte_in, lsb_q, spi_cfg_pkg::STEP_UP_HI,
                                 spi_cfg_pkg::STEP_UP_LO);
   assign first_sdo = first_bit(byte_in, lsb_q, spi_cfg_pkg::SDO_ACT_HI,
                                spi_cfg_pkg::SDO_ACT_LO);

   always_ff @(posedge sclk or negedge rstn) begin
      if (!rstn) begin
         lsb_q <= spi_cfg_pkg::LSB_FIRST_RST; // see R12
         step_q <= spi_cfg_pkg::STEP_UP_RST;
         sdo_act_q <= spi_cfg_pkg::SDO_ACT_RST;
      end else if (cfg_wr && soft_rst) begin
         lsb_q <= spi_cfg_pkg::LSB_FIRST_RST;
         step_q <= spi_cfg_pkg::STEP_UP_RST;
         sdo_act_q <= spi_cfg_pkg::SDO_ACT_RST;
      end else if (cfg_wr) begin
         lsb_q <= first_lsb; // see R15
         step_q <= first_step; // see R15
         sdo_act_q <= first_sdo; // see R15
      end
   end

   // mirrored readback, soft reset bits read zero
   always_comb begin
      cfg_byte = 8'h00;
      cfg_byte[spi_cfg_pkg::LSB_FIRST_HI] = lsb_q;
      cfg_byte[spi_cfg_pkg::LSB_FIRST_LO] = lsb_q;
      cfg_byte[spi_cfg_pkg::STEP_UP_HI] = step_q;
      cfg_byte[spi_cfg_pkg::STEP_UP_LO] = step_q;
      cfg_byte[spi_cfg_pkg::SDO_ACT_HI] = sdo_act_q;
      cfg_byte[spi_cfg_pkg::SDO_ACT_LO] = sdo_act_q;
   end

   // -----------------------------------------------------------
   // tuning word staging and load request
   // -----------------------------------------------------------
   // staged bytes wait until the load request
   generate
      for (genvar n = 0; n < NN; n++) begin : g_stage
         always_ff @(posedge sclk or negedge rstn) begin
            if (!rstn) begin
               stage_q[n] <= '0;
               hold_q[n] <= '0;
               tog_q[n] <= 1'b0;
            end else begin
               if (wr_commit && wr_slot[4] &&
                   (wr_slot[3] == 1'(n))) begin
                  stage_q[n][{wr_slot[2:0], 3'b000} +: 8] <=
                     byte_in; // see R4
               end
               if (load_wr && byte_in[n]) begin
                  hold_q[n] <= stage_q[n]; // see R4
                  tog_q[n] <= ~tog_q[n];
               end
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------
   // read fetch
   // -----------------------------------------------------------
   assign rd_slot = ftw_slot(rd_addr);
   assign stage_rd =
      stage_q[rd_slot[3]][{rd_slot[2:0], 3'b000} +: 8];
   assign other_d = (rd_addr == spi_cfg_pkg::CFG_ADDR) ? cfg_byte :
                    rd_slot[4] ? stage_rd : 8'h00;
   assign use_mem_d = in_mem(rd_addr);

   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         other_q <= 8'h00;
         use_mem_q <= 1'b0;
      end else if (rd_issue) begin
         other_q <= other_d;
         use_mem_q <= use_mem_d;
      end
   end

   assign mem_port.we = wr_commit && in_mem(addr_q); // see R4
   assign mem_port.waddr = addr_q[AW-1:0];
   assign mem_port.wdata = byte_in;
   assign mem_port.re = rd_issue;
   assign mem_port.raddr = rd_addr[AW-1:0];

   cfg_byte_mem #(.DEPTH(MEM_DEPTH), .AW(AW)) u_mem (
      .clk(sclk),
      .rstn(rstn),
      .port(mem_port)
   );

   // -----------------------------------------------------------
   // transmit path
   // -----------------------------------------------------------
   assign tx_load = data_q && rw_q && (bidx_q == 3'h0);
   assign tx_fetch = use_mem_q ? mem_port.rdata : other_q;
   assign tx_shift = lsb_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
   assign tx_d = tx_load ? tx_fetch : tx_shift;
   assign tx_bit = lsb_q ? tx_d[0] : tx_d[7]; // see R13

   // launching on the falling edge
   always_ff @(negedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         tx_q <= 8'h00;
         out_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         tx_q <= tx_d;
         out_q <= tx_bit; // see R8
         drive_q <= data_q && rw_q; // see R16
      end
   end

   assign sdo_out = out_q;
   assign sdio_out = out_q;
   assign sdo_oe = drive_q && sdo_act_q; // see R14
   assign sdio_oe = drive_q && !sdo_act_q; // see R10

   // -----------------------------------------------------------
   // core domain: tuning word takeover
   // -----------------------------------------------------------
   logic [NN-1:0][FW-1:0] word_q;
   logic [NN-1:0] upd_q;

   generate
      for (genvar n = 0; n < NN; n++) begin : g_core
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic acc_q;
         logic ev;
         // accept only once the later two stages agree
         assign ev = (s2_q == s3_q) && (s3_q != acc_q);
         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
            end else begin
               s1_q <= tog_q[n];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               acc_q <= 1'b0;
               word_q[n] <= '0;
               upd_q[n] <= 1'b0;
            end else begin
               upd_q[n] <= ev;
               if (ev) begin
                  acc_q <= s3_q;
                  word_q[n] <= hold_q[n]; // see R4
               end
            end
         end
      end
   endgenerate

   assign main_tuning_word = word_q[spi_cfg_pkg::LOAD_MAIN_BIT];
   assign channel_tuning_word = word_q[spi_cfg_pkg::LOAD_CHAN_BIT];
   assign main_tuning_update = upd_q[spi_cfg_pkg::LOAD_MAIN_BIT];
   assign channel_tuning_update =
      upd_q[spi_cfg_pkg::LOAD_CHAN_BIT];
endmodule

/* File: test/serial_config_port_asserts.sv */
// pin-level checks of the serial configuration port
module serial_config_port_asserts #(
   parameter int MEM_DEPTH = 64
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_oe,
   input wire logic sdo_oe,
   input wire logic [spi_cfg_pkg::FTW_W-1:0] main_tuning_word,
   input wire logic [spi_cfg_pkg::FTW_W-1:0] channel_tuning_word,
   input wire logic main_tuning_update,
   input wire logic channel_tuning_update
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // rise counter of the current frame
   // ----------------------------------------
   logic [7:0] rise_q;
   wire logic any_oe = sdio_oe | sdo_oe;
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rise_q <= 8'h00;
      end else if (rise_q != 8'hFF) begin
         rise_q <= rise_q + 8'h01;
      end
   end
   property p_idle_release;
      @(posedge core_clk) disable iff (!rstn) cs_n |-> !any_oe;
   endproperty
   a_idle_release: assert property (p_idle_release)
      else $error("data pin driven while deselected");
   property p_one_pin;
      @(posedge core_clk) disable iff (!rstn) !(sdio_oe && sdo_oe);
   endproperty
   a_one_pin: assert property (p_one_pin)
      else $error("both data outputs enabled");
   property p_no_oe_instr;
      @(posedge sclk) disable iff (!rstn || cs_n)
         (rise_q < 8'h10) |-> !any_oe;
   endproperty
   a_no_oe_instr: assert property (p_no_oe_instr)
      else $error("output enabled during instruction");
   property p_oe_start;
      @(posedge sclk) disable iff (!rstn || cs_n)
         $rose(any_oe) |-> rise_q == 8'h10;
   endproperty
   a_oe_start: assert property (p_oe_start)
      else $error("read data started at wrong edge");
   property p_oe_hold;
      @(posedge sclk) disable iff (!rstn || cs_n)
         (rise_q > 8'h10 && $past(any_oe)) |-> any_oe;
   endproperty
   a_oe_hold: assert property (p_oe_hold)
      else $error("output enable dropped inside frame");
   property p_main_pulse;
      @(posedge core_clk) disable iff (!rstn)
         main_tuning_update |=> !main_tuning_update;
   endproperty
   a_main_pulse: assert property (p_main_pulse)
      else $error("main update longer than one cycle");
   property p_chan_pulse;
      @(posedge core_clk) disable iff (!rstn)
         channel_tuning_update |=> !channel_tuning_update;
   endproperty
   a_chan_pulse: assert property (p_chan_pulse)
      else $error("channel update longer than one cycle");
   property p_main_word;
      @(posedge core_clk) disable iff (!rstn)
         $changed(main_tuning_word) |-> main_tuning_update;
   endproperty
   a_main_word: assert property (p_main_word)
      else $error("main word changed without update");
   property p_chan_word;
      @(posedge core_clk) disable iff (!rstn)
         $changed(channel_tuning_word) |-> channel_tuning_update;
   endproperty
   a_chan_word: assert property (p_chan_word)
      else $error("channel word changed without update");
   c_read: cover property (@(posedge sclk) $rose(sdio_oe));
   c_four: cover property (@(posedge sclk) $rose(sdo_oe));
   c_main: cover property (@(posedge core_clk) main_tuning_update);
endmodule
bind serial_config_port serial_config_port_asserts #(
   .MEM_DEPTH(MEM_DEPTH)
) u_chk (
   .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
   .sdio_oe(sdio_oe), .sdo_oe(sdo_oe),
   .main_tuning_word(main_tuning_word),
   .channel_tuning_word(channel_tuning_word),
   .main_tuning_update(main_tuning_update),
   .channel_tuning_update(channel_tuning_update)
);

/* File: test/host_model.sv */
// serial master model driving frames into the configuration port
module host_model (
   output logic sclk,
   output logic cs_n,
   output logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   output logic [7:0] rd_byte,
   output logic rd_done
);
   timeunit 1ns;
   timeprecision 100ps;
   logic host_do;
   logic host_rel;
   // shared pin: device when enabled, inverse when nobody drives
   assign sdio_in = sdio_oe ? sdio_out : host_rel ? ~sdio_out : host_do;
   initial begin
      host_rel = 1'b0;
      sclk = 1'b0;
      cs_n = 1'b1;
      host_do = 1'b0;
      rd_byte = 8'h00;
      rd_done = 1'b0;
   end
   // ----------------------------------------
   // one frame; cut stops it after that many bits
   // ----------------------------------------
   task automatic frame(input logic rd, input logic [14:0] adr,
         input logic [7:0] d [8], input int n, input logic lsb,
         input logic four, input int cut);
      logic [15:0] w;
      logic [7:0] rb;
      logic bi;
      logic sb;
      int j;
      w = {rd, adr};
      cs_n = 1'b0;
      for (int k = 0; k < 16 + 8 * n; k++) begin
         if (cut != 0 && k == cut) break;
         j = (k - 16) % 8;
         if (k < 16) bi = lsb ? w[k] : w[15 - k];
         else bi = d[(k - 16) / 8][lsb ? j : 7 - j];
         host_rel = rd && k >= 16;
         if (!host_rel) host_do = bi;
         #7.5;
         sclk = 1'b1;
         if (rd && k >= 16) begin
            sb = sdo_oe ? sdo_out : ~sdo_out;
            rb[lsb ? j : 7 - j] = four ? sb : sdio_in;
            rd_byte = rb;
            rd_done = (j == 7);
         end
         #7.5;
         sclk = 1'b0;
         rd_done = 1'b0;
      end
      #7.5;
      cs_n = 1'b1;
      host_do = ~host_do;
      host_rel = 1'b0;
      #15;
   endtask
endmodule

/* File: test/tb.sv */
// self-checking bench for the serial configuration port
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rstn;
   wire logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, sdo_out, sdo_oe;
   wire logic main_upd, chan_upd, rd_done;
   wire logic [47:0] main_word, chan_word;
   wire logic [7:0] rd_byte;
   logic [7:0] d [8];
   logic [7:0] e [8];
   logic [7:0] s [8];
   logic [47:0] w [2];
   logic [47:0] exp_q [$];
   int errors, n_checks, cyc;
   initial core_clk = 1'b0;
   always #20 core_clk = ~core_clk;
   serial_config_port uut (
      .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .main_tuning_word(main_word), .channel_tuning_word(chan_word),
      .main_tuning_update(main_upd), .channel_tuning_update(chan_upd)
   );
   host_model host (
      .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
      .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .rd_byte(rd_byte), .rd_done(rd_done)
   );
   // ----------------------------------------
   // comparison and result watchers
   // ----------------------------------------
   task automatic check(input logic [47:0] seen, input logic [47:0] want);
      n_checks++;
      if (seen !== want) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic take(input logic [47:0] seen);
      if (exp_q.size() == 0) check(seen, 48'hZZZZZZZZZZZZ);
      else check(seen, exp_q.pop_front());
   endtask
   always @(posedge rd_done) take({40'h0, rd_byte});
   always @(negedge core_clk) if (main_upd === 1'b1) take(main_word);
   always @(negedge core_clk) if (chan_upd === 1'b1) take(chan_word);
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end
   task automatic wr(input logic [14:0] a, input int n, input int lsb,
         input int cut);
      host.frame(1'b0, a, d, n, 1'(lsb), 1'b0, cut);
   endtask
   task automatic rd(input logic [14:0] a, input int n, input int lsb,
         input int four);
      for (int k = 0; k < n; k++) exp_q.push_back({40'h0, e[k]});
      host.frame(1'b1, a, d, n, 1'(lsb), 1'(four), 0);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      errors = 0;
      n_checks = 0;
      cyc = 0;
      rstn = 1'b0;
      void'($urandom(32'h4A2F));
      repeat (16) @(negedge core_clk);
      rstn = 1'b1;
      repeat (2) @(negedge core_clk);
      e[0] = 8'h00;
      rd(15'h0000, 1, 0, 0);
      foreach (d[k]) d[k] = 8'($urandom);
      s = d;
      wr(15'h0022, 3, 0, 0);
      e = s;
      rd(15'h0022, 3, 0, 0);
      foreach (d[k]) d[k] = 8'($urandom);
      wr(15'h0020, 1, 0, 9);
      wr(15'h0020, 1, 0, 21);
      e[0] = s[2];
      rd(15'h0020, 1, 0, 0);
      d[0] = 8'h30;
      wr(15'h0000, 1, 0, 0);
      e[0] = 8'h3C;
      rd(15'h0000, 1, 0, 1);
      e[0] = s[2];
      e[1] = s[1];
      e[2] = s[0];
      rd(15'h0020, 3, 0, 1);
      d[0] = 8'h7F;
      wr(15'h0000, 1, 0, 0);
      e[0] = 8'h7E;
      rd(15'h0000, 1, 1, 1);
      foreach (d[k]) d[k] = 8'($urandom);
      e = d;
      wr(15'h0031, 2, 1, 0);
      rd(15'h0031, 2, 1, 1);
      d[0] = 8'h01;
      wr(15'h0000, 1, 1, 0);
      e[0] = 8'h00;
      rd(15'h0000, 1, 0, 0);
      d[0] = 8'($urandom);
      wr(15'h0040, 1, 0, 0);
      rd(15'h0040, 1, 0, 0);
      for (int t = 0; t < 2; t++) begin
         w[t] = {16'($urandom), 32'($urandom)};
         for (int k = 0; k < 6; k++) d[k] = w[t][8 * (5 - k) +: 8];
         wr(t ? 15'h001D : 15'h0015, 6, 0, 0);
      end
      for (int k = 0; k < 6; k++) e[k] = w[0][8 * (5 - k) +: 8];
      rd(15'h0015, 6, 0, 0);
      check(main_word, 48'h0);
      check(chan_word, 48'h0);
      for (int t = 0; t < 2; t++) begin
         exp_q.push_back(w[t]);
         d[0] = t ? 8'h02 : 8'h01;
         wr(15'h0008, 1, 0, 0);
         repeat (10) @(negedge core_clk);
      end
      check(main_word, w[0]);
      check(48'(exp_q.size()), 48'h0);
      finish_test();
   end
endmodule
